// ---- flag_conditional_branch_unit.sv ----
// top: decode and execute of four flag-conditional relative branches
//
// What this block does
// [RULE_01] Opcode E6 branches only when the negative flag is one.
// [RULE_02] Opcode E3 branches only when the carry flag is zero.
// [RULE_03] Opcode E7 branches only when the negative flag is zero.
// [RULE_04] Opcode E5 branches only when the overflow flag is zero.
// [RULE_05] The low byte is a signed offset from -128 to +127.
// [RULE_06] The offset is doubled as two's complement so targets are even.
// [RULE_07] The target is the branch address plus two plus twice the offset.
// [RULE_08] One word; one cycle untaken, two cycles taken.
// [RULE_09] Decode Q1, read Q2, process Q3, write pc Q4, then an idle cycle.
// [RULE_10] No status flag changes, taken or not.
`timescale 1ns/1ns
`default_nettype none
module flag_conditional_branch_unit
  import branch_pkg::*;
#(
  parameter int PCW = branch_pkg::PC_WIDTH
) (
  // clock and reset
  input  wire logic           core_clk,
  input  wire logic           sys_rst,
  // instruction from fetch, with its address already advanced by two
  input  wire logic           instr_valid,
  input  wire logic [15:0]    instr_word,
  input  wire logic [PCW-1:0] pc_advanced,
  // status flags from the core
  input  wire logic [7:0]     status_in,
  // results
  output logic                pc_load,
  output logic [PCW-1:0]      pc_value,
  output logic                flush_idle,
  output logic                is_branch,
  output logic                retire,
  output logic [7:0]          status_out,
  output logic [1:0]          phase
);
  import branch_pkg::*;
  initial begin
    if (PCW > 32 || PCW < 10) $error("unsupported pc width");
  end
  // ==========================================================
  // state
  phase_type      ph_q, ph_d;
  logic           hit_q, hit_d;
  logic           take_q, take_d;
  logic           idle_q, idle_d;
  logic [7:0]     off_q, off_d;
  logic [PCW-1:0] base_q, base_d;
  logic [PCW-1:0] tgt_q, tgt_d;
  logic           load_q, load_d;
  logic           ret_q, ret_d;
  logic [7:0]     stat_q, stat_d;
  logic [PCW-1:0] sum;
  logic           dec_hit;
  logic           cond;
  // ==========================================================
  // decode
  always_comb begin
    dec_hit = 1'b0;
    cond    = 1'b0;
    if (instr_word[GROUP_MSB -: 4] == OPC_GROUP) begin
      case (instr_word[SUB_MSB -: 4])
        OPC_NEG_SET: begin
          dec_hit = 1'b1;
          cond    = status_in[FLAG_N_POS]; // see [RULE_01]
        end
        OPC_CARRY_CLR: begin
          dec_hit = 1'b1;
          cond    = ~status_in[FLAG_C_POS]; // see [RULE_02]
        end
        OPC_NEG_CLR: begin
          dec_hit = 1'b1;
          cond    = ~status_in[FLAG_N_POS]; // see [RULE_03]
        end
        OPC_OVF_CLR: begin
          dec_hit = 1'b1;
          cond    = ~status_in[FLAG_OV_POS]; // see [RULE_04]
        end
        default: begin
          dec_hit = 1'b0;
          cond    = 1'b0;
        end
      endcase
    end
  end
  branch_target_adder #(.PCW(PCW)) u_adder (
    .pc_next (base_q),
    .offset  (off_q),
    .target  (sum)
  );
  // ==========================================================
  // phase sequencer
  always_comb begin
    ph_d   = ph_q;
    hit_d  = hit_q;
    take_d = take_q;
    idle_d = idle_q;
    off_d  = off_q;
    base_d = base_q;
    tgt_d  = tgt_q;
    load_d = 1'b0;
    ret_d  = 1'b0;
    stat_d = status_in; // see [RULE_10]
    case (ph_q)
      Q1: begin
        ph_d = Q2;
        // an idle cycle ignores whatever fetch presents
        if (!idle_q) begin
          hit_d  = instr_valid && dec_hit; // see [RULE_09]
          take_d = instr_valid && dec_hit && cond;
          base_d = pc_advanced; // see [RULE_07]
        end else begin
          hit_d  = 1'b0;
          take_d = 1'b0;
        end
      end
      Q2: begin
        ph_d = Q3;
        if (hit_q) begin
          off_d = instr_word[OFFSET_MSB:0]; // see [RULE_09]
        end
      end
      Q3: begin
        ph_d  = Q4;
        tgt_d = sum; // see [RULE_06]
      end
      Q4: begin
        ph_d = Q1;
        if (take_q) begin
          load_d = 1'b1; // see [RULE_09]
          idle_d = 1'b1; // see [RULE_08]
        end else begin
          idle_d = 1'b0;
          ret_d  = hit_q || idle_q; // see [RULE_08]
        end
        take_d = 1'b0;
      end
      default: ph_d = Q1;
    endcase
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_q   <= Q1;
      hit_q  <= 1'b0;
      take_q <= 1'b0;
      idle_q <= 1'b0;
      off_q  <= 8'h00;
      base_q <= PC_RESET[PCW-1:0];
      tgt_q  <= PC_RESET[PCW-1:0];
      load_q <= 1'b0;
      ret_q  <= 1'b0;
      stat_q <= 8'h00;
    end else begin
      ph_q   <= ph_d;
      hit_q  <= hit_d;
      take_q <= take_d;
      idle_q <= idle_d;
      off_q  <= off_d;
      base_q <= base_d;
      tgt_q  <= tgt_d;
      load_q <= load_d;
      ret_q  <= ret_d;
      stat_q <= stat_d;
    end
  end
  assign pc_load    = load_q;
  assign pc_value   = tgt_q;
  assign flush_idle = idle_q;
  assign is_branch  = hit_q;
  assign retire     = ret_q;
  assign status_out = stat_q;
  assign phase      = ph_q;
  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_LOAD_EVEN: assert property (pc_load |-> pc_value[0] == 1'b0) // see [RULE_06]
    else $error("branch target odd");
  AST_LOAD_AT_Q1: assert property (pc_load |-> ph_q == Q1 && idle_q) // see [RULE_09]
    else $error("pc load off phase");
  AST_TARGET: assert property (ph_q == Q4 && hit_q |=> // see [RULE_07]
      tgt_q == base_q + {{(PCW-9){off_q[7]}}, off_q, 1'b0})
    else $error("wrong target");
  AST_NO_LOAD_UNTAKEN: assert property (ph_q == Q4 && !take_q |=> !pc_load) // see [RULE_08]
    else $error("untaken load");
  AST_IDLE_LEN: assert property ($rose(idle_q) |-> idle_q [*4] ##1 !idle_q) // see [RULE_08]
    else $error("idle cycle length");
  AST_IDLE_NO_HIT: assert property (ph_q == Q1 && idle_q |=> !hit_q) // see [RULE_09]
    else $error("decode in idle cycle");
  AST_FLAGS: assert property (status_out == $past(status_in)) // see [RULE_10]
    else $error("flags altered");
  AST_NEG_SET: assert property (ph_q == Q1 && !idle_q && instr_valid
      && instr_word[15:8] == 8'hE6 |=> take_q == $past(status_in[4])) // see [RULE_01]
    else $error("neg set cond");
  AST_CARRY_CLR: assert property (ph_q == Q1 && !idle_q && instr_valid
      && instr_word[15:8] == 8'hE3 |=> take_q == !$past(status_in[0])) // see [RULE_02]
    else $error("carry clr cond");
  AST_NEG_CLR: assert property (ph_q == Q1 && !idle_q && instr_valid
      && instr_word[15:8] == 8'hE7 |=> take_q == !$past(status_in[4])) // see [RULE_03]
    else $error("neg clr cond");
  AST_OVF_CLR: assert property (ph_q == Q1 && !idle_q && instr_valid
      && instr_word[15:8] == 8'hE5 |=> take_q == !$past(status_in[3])) // see [RULE_04]
    else $error("ovf clr cond");
  COV_TAKEN: cover property (pc_load);
  COV_UNTAKEN: cover property (ph_q == Q4 && hit_q && !take_q);
  COV_BACKWARD: cover property (pc_load && off_q[7]);
endmodule // flag_conditional_branch_unit
`default_nettype wire

// ---- branch_pkg.sv ----
// package: encodings, phase and timing constants for the branch unit
package branch_pkg;
  localparam int          PC_WIDTH        = 21;
  localparam logic [3:0]  OPC_GROUP       = 4'hE;
  localparam logic [3:0]  OPC_NEG_SET     = 4'h6;
  localparam logic [3:0]  OPC_CARRY_CLR   = 4'h3;
  localparam logic [3:0]  OPC_NEG_CLR     = 4'h7;
  localparam logic [3:0]  OPC_OVF_CLR     = 4'h5;
  localparam int          GROUP_MSB       = 15;
  localparam int          SUB_MSB         = 11;
  localparam int          OFFSET_MSB      = 7;
  localparam int          OFFSET_MIN      = -128;
  localparam int          OFFSET_MAX      = 127;
  localparam int          FLAG_C_POS      = 0;
  localparam int          FLAG_OV_POS     = 3;
  localparam int          FLAG_N_POS      = 4;
  localparam logic [1:0]  PHASE_RESET     = 2'h0;
  localparam int          PHASES_PER_CYCLE = 4;
  localparam int          TAKEN_CYCLES    = 2;
  localparam int          UNTAKEN_CYCLES  = 1;
  localparam logic [20:0] PC_RESET        = 21'h000000;
  localparam logic [20:0] PC_STEP         = 21'h000002;
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_type;
endpackage

// ---- branch_target_adder.sv ----
// leaf: doubled sign-extended offset added to the advanced counter
`timescale 1ns/1ns
`default_nettype none
module branch_target_adder #(
  parameter int PCW = 21
) (
  // operands
  input  wire logic [PCW-1:0] pc_next,
  input  wire logic [7:0]     offset,
  // result
  output logic [PCW-1:0]      target
);
  logic [PCW-1:0] disp;
  initial begin
    if (PCW < 10) $error("pc width too small");
  end
  // sign extend then shift left one: always an even step
  assign disp   = {{(PCW-9){offset[7]}}, offset, 1'b0}; // see [RULE_05] see [RULE_06]
  assign target = pc_next + disp; // see [RULE_07]
endmodule // branch_target_adder
`default_nettype wire

// ---- flag_conditional_branch_unit_test.sv ----
// testbench: corner and random branches through the branch unit
`timescale 1ns/1ns
`default_nettype none
module flag_conditional_branch_unit_test;
  // ==========================================
  // signals and design
  logic        core_clk    = 1'b0;
  logic        sys_rst     = 1'b1;
  logic        instr_valid = 1'b0;
  logic [15:0] instr_word  = 16'h0000;
  logic [20:0] pc_advanced = 21'h000000;
  logic [7:0]  status_in   = 8'h00;
  logic        pc_load, flush_idle, is_branch, retire;
  logic [20:0] pc_value;
  logic [7:0]  status_out;
  logic [1:0]  phase;
  int          n_mismatch  = 0;
  int          check_count = 0;
  logic [7:0]  codes [4]   = '{8'hE6, 8'hE3, 8'hE7, 8'hE5};

  always #10 core_clk = ~core_clk;

  flag_conditional_branch_unit dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .pc_advanced(pc_advanced),
    .status_in(status_in), .pc_load(pc_load), .pc_value(pc_value),
    .flush_idle(flush_idle), .is_branch(is_branch), .retire(retire),
    .status_out(status_out), .phase(phase));

  // ==========================================
  // expectations and compares
  function automatic logic [1:0] exp_br(logic [15:0] w, logic [7:0] s);
    case (w[15:8])
      8'hE6: return {1'b1, s[4]};
      8'hE3: return {1'b1, !s[0]};
      8'hE7: return {1'b1, !s[4]};
      8'hE5: return {1'b1, !s[3]};
      default: return 2'b00;
    endcase
  endfunction

  task automatic chk_bit(string nm, logic e, logic g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic chk_vec(string nm, logic [20:0] e, logic [20:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // called at the falling edge just before a decode edge
  task automatic run(logic v, logic [15:0] w, logic [20:0] pc,
                     logic [7:0] s);
    logic m, t;
    {m, t} = exp_br(w, s);
    m = m & v;
    t = t & m;
    instr_valid = v;
    instr_word = w;
    pc_advanced = pc;
    status_in = s;
    @(negedge core_clk);
    chk_bit("is_branch", m, is_branch);
    chk_vec("status_out", {13'h0, s}, {13'h0, status_out});
    repeat (3) @(negedge core_clk);
    chk_vec("phase", 21'h0, {19'h0, phase});
    chk_bit("pc_load", t, pc_load);
    chk_bit("retire", m & !t, retire);
    chk_bit("flush_idle", t, flush_idle);
    if (t) begin
      chk_vec("pc_value", pc + {{12{w[7]}}, w[7:0], 1'b0}, pc_value);
      // decoy during the idle cycle: would branch if not ignored
      instr_word = 16'hE740;
      status_in = 8'h00;
      repeat (3) @(negedge core_clk);
      chk_bit("flush_idle", 1'b1, flush_idle);
      @(negedge core_clk);
      chk_bit("pc_load", 1'b0, pc_load);
      chk_bit("retire", 1'b1, retire);
    end
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    logic [15:0] w;
    void'($urandom(52243));
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      w = {codes[i / 2], (i % 2) ? 8'h7F : 8'h80};
      run(1'b1, w, 21'h000200, (i % 2) ? 8'hFF : 8'h00);
    end
    run(1'b1, 16'hE2FF, 21'h000002, 8'hFF);
    run(1'b0, 16'hE680, 21'h000002, 8'hFF);
    run(1'b1, 16'hE380, 21'h000002, 8'h00);
    for (int i = 0; i < 70; i++) begin
      w = 16'($urandom);
      w[15:11] = 5'h1C;
      run(($urandom % 8) != 0, w, 21'($urandom) & 21'h1FFFFE,
          8'($urandom));
    end
    end_of_test();
  end

  initial begin
    #(3 * 81 * 8 * 20);
    n_mismatch++;
    end_of_test();
  end
endmodule // flag_conditional_branch_unit_test
`default_nettype wire
